// File: pkg/rpm_map.svh
// offsets, field positions, reset values and timing counts of the radio power controller
`ifndef RPM_MAP_SVH
`define RPM_MAP_SVH

`define RPM_CLK_PERIOD_PS     32'd4000
`define RPM_WAKE_INIT_NS      32'd1000
`define RPM_WAKE_INIT_CYC     ((`RPM_WAKE_INIT_NS * 32'd1000) / `RPM_CLK_PERIOD_PS)
`define RPM_SEL_HIGH_NS       32'd100
`define RPM_SEL_HIGH_CYC      (((`RPM_SEL_HIGH_NS * 32'd1000) + `RPM_CLK_PERIOD_PS - 32'd1) / `RPM_CLK_PERIOD_PS)
`define RPM_WIRE_LATENCY_BITS 6
`define RPM_BIT_DIV_DEFAULT   25000

`define RPM_ADDR_PMC          7'h00
`define RPM_ADDR_PSTAT        7'h01
`define RPM_ADDR_XTAL         7'h02
`define RPM_ADDR_IFMODE       7'h03
`define RPM_ADDR_FIFO         7'h04
`define RPM_ADDR_IRQMASK      7'h05
`define RPM_ADDR_IRQSTAT      7'h06

`define RPM_PMC_RST_BIT       7
`define RPM_PM_POWERDOWN      4'h0
`define RPM_PM_DEEPSLEEP      4'h1
`define RPM_PM_STANDBY        4'h5
`define RPM_PM_FULLRX         4'h9
`define RPM_PM_FULLTX         4'hD
`define RPM_PMC_RESET         8'h00

`define RPM_IF_WIRE_BIT       0
`define RPM_IF_ASYNC_BIT      1
`define RPM_IF_PREAMBLE_BIT   2
`define RPM_IF_CRC_BIT        3
`define RPM_IFMODE_RESET      4'hC

`define RPM_XTAL_RESET        6'h08
`define RPM_IRQMASK_RESET     2'h0
`define RPM_FIFO_UNDEF        8'hFF

`endif

// File: pkg/rpm_pkg.sv
// types of the radio power controller
package rpm_pkg;

    typedef enum logic [2:0] {
        RPM_SLEEP,
        RPM_WAKE,
        RPM_PDOWN,
        RPM_RAMP,
        RPM_ACTIVE
    } rpm_state_t;

    typedef struct packed {
        rpm_state_t  state;
        logic [31:0] cnt;
        logic        sel_armed;
        logic [2:0]  tgl_seen;
        logic [7:0]  pmc;
        logic        osc_en;
        logic [5:0]  xtal;
        logic [3:0]  ifmode;
        logic [1:0]  irq_mask;
        logic [7:0]  rd_data;
        logic        fifo_wr;
        logic        fifo_rd;
        logic        fifo_flush;
        logic [7:0]  fifo_wdata;
        logic        irq;
        logic        reg_core_en;
        logic        reg_ana_en;
        logic        rx_en;
        logic        tx_en;
        logic        reg_ready;
        logic        brownout;
        logic        ready;
        logic [15:0] bit_cnt;
        logic        bit_clk;
        logic [5:0]  delay_line;
        logic        wire_out;
        logic        wire_oe;
        logic        tx_bit;
        logic        wire_in_prev;
        logic        start_armed;
    } rpm_core_t;

    typedef struct packed {
        logic [3:0]  bit_cnt;
        logic [14:0] shift;
    } rpm_link_shift_t;

endpackage

// File: pkg/rpm_spi_if.sv
// carrier between the spi link logic and the core logic
`timescale 1ns/1ps
interface rpm_spi_if;
    logic [15:0] word;
    logic        req_tgl;
    logic [7:0]  rd_data;

    modport link (output word, output req_tgl, input rd_data);
    modport core (input word, input req_tgl, output rd_data);
endinterface

// File: design/rpm_spi_link.sv
// spi slave logic running on the host serial clock
`timescale 1ns/1ps
module rpm_spi_link
    import rpm_pkg::*;
(
    input  wire logic  spi_sck,
    input  wire logic  spi_sel_n,
    input  wire logic  spi_mosi,
    input  wire logic  rst_n,
    output logic       miso_bit,
    rpm_spi_if.link    bus
);
    rpm_link_shift_t sh_q;
    rpm_link_shift_t sh_d;
    logic [15:0]     word_q;
    logic            tgl_q;
    logic            miso_q;

    always_comb begin
        sh_d = sh_q;
        sh_d.bit_cnt = sh_q.bit_cnt + 4'h1;
        sh_d.shift = {sh_q.shift[13:0], spi_mosi};
    end

    // frame state ends with the select line
    always_ff @(posedge spi_sck or posedge spi_sel_n or negedge rst_n) begin
        if (!rst_n || spi_sel_n) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    // completed words survive between frames; one toggle per word
    always_ff @(posedge spi_sck or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= 16'h0000;
            tgl_q <= 1'b0;
        end else if (!spi_sel_n && sh_q.bit_cnt == 4'hF) begin
            word_q <= {sh_q.shift, spi_mosi}; // R8
            tgl_q <= ~tgl_q;
        end
    end

    // idle level high so a polling host sees readiness; read byte on bits 1..8
    always_ff @(negedge spi_sck or posedge spi_sel_n or negedge rst_n) begin
        if (!rst_n || spi_sel_n) begin
            miso_q <= 1'b1;
        end else if (sh_q.bit_cnt >= 4'h1 && sh_q.bit_cnt <= 4'h8) begin
            miso_q <= bus.rd_data[3'(4'h8 - sh_q.bit_cnt)];
        end else begin
            miso_q <= 1'b0;
        end
    end

    assign bus.word = word_q;
    assign bus.req_tgl = tgl_q;
    assign miso_bit = miso_q;
endmodule

// File: design/rpm_ctrl.sv
// radio power-mode sequencer, interface-mode control and wire-mode bit path
// Operation
// R1: frame mode moves payload only through spi fifo accesses, both directions.
// R2: frame mode enables automatic preamble, postamble and checksum generation.
// R3: frame mode raises interrupt on fifo flow conditions; host paces by them.
// R4: wire mode disables packet controller, puts raw modem bits on data pin.
// R5: wire mode drives the bit clock on its own pin beside data.
// R6: in wire mode host does coding, checksums, preambles and postambles.
// R7: wire mode sync or async; async resyncs transmit timing on start bits.
// R8: device is spi slave in both modes; all configuration arrives over spi.
// R9: writing a power mode makes device sequence regulators before rx or tx.
// R10: status register shows regulators ready and io supply below brown-out.
// R11: power-down keeps registers, refuses fifo access, discards fifo contents.
// R12: power-down still serves register access, at reduced spi clock speed.
// R13: deep sleep turns off all supplies and functions, losing every register.
// R14: select low wakes from deep sleep; device starts up with full reset.
// R15: miso held low during wake initialization, raised high when ready.
// R16: oscillator on after power-up, then follows the written power mode.
// R17: six-bit crystal tuning field selects the capacitor bank setting.
// R18: host uses at least 100 ns serial clock period during power-down.
// R19: select high 100 ns then set and clear reset bit restores defaults.
// R20: wire mode adds about six bit periods of latency to the pins.
// R21: power-down ignores fifo writes, returns undefined fifo reads, state intact.
// R22: brown-out clears only when supply returns; ready low while supplies bad.
`timescale 1ns/1ps
`include "rpm_map.svh"
module rpm_ctrl
    import rpm_pkg::*;
#(
    parameter int BIT_DIV = `RPM_BIT_DIV_DEFAULT
)(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        spi_sck,
    input  wire logic        spi_sel_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    input  wire logic        vio_ok,
    input  wire logic        regs_good,
    input  wire logic        modem_rx_bit,
    input  wire logic        wire_data_in,
    output logic             wire_data_out,
    output logic             wire_data_oe,
    output logic             wire_bit_clock_pin,
    output logic             modem_tx_bit,
    output logic             reg_core_en,
    output logic             reg_ana_en,
    output logic             osc_en,
    output logic             rx_en,
    output logic             tx_en,
    output logic             pkt_ctrl_en,
    output logic             frame_preamble_en,
    output logic             frame_crc_en,
    output logic             spi_slow,
    output logic [5:0]       crystal_tuning_cap,
    output logic             fifo_wr,
    output logic             fifo_rd,
    output logic             fifo_flush,
    output logic [7:0]       fifo_wdata,
    input  wire logic [7:0]  fifo_rdata,
    input  wire logic        fifo_not_empty,
    input  wire logic        fifo_has_space,
    output logic             irq
);
    localparam int         WAKE_CYC = (`RPM_WAKE_INIT_CYC < 1) ? 1 : `RPM_WAKE_INIT_CYC;
    localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);
    localparam logic [15:0] DIV_HALF = 16'(BIT_DIV / 2);

    initial begin
        if (BIT_DIV < 4 || BIT_DIV > 65535) begin
            $error("BIT_DIV out of range");
        end
    end

    rpm_spi_if bus ();
    logic      miso_bit;

    rpm_spi_link u_link (
        .spi_sck   (spi_sck),
        .spi_sel_n (spi_sel_n),
        .spi_mosi  (spi_mosi),
        .rst_n     (rst_n),
        .miso_bit  (miso_bit),
        .bus       (bus.link)
    );

    // two-flop synchronisers for pins and the link-domain toggle
    logic [1:0] sel_s_q;
    logic [1:0] tgl_s_q;
    logic [1:0] vio_s_q;
    logic [1:0] rgood_s_q;
    logic [1:0] wire_s_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_s_q <= 2'h3;
            tgl_s_q <= 2'h0;
            vio_s_q <= 2'h0;
            rgood_s_q <= 2'h0;
            wire_s_q <= 2'h3;
        end else begin
            sel_s_q <= {sel_s_q[0], spi_sel_n};
            tgl_s_q <= {tgl_s_q[0], bus.req_tgl};
            vio_s_q <= {vio_s_q[0], vio_ok};
            rgood_s_q <= {rgood_s_q[0], regs_good};
            wire_s_q <= {wire_s_q[0], wire_data_in};
        end
    end

    logic sel_n_s;
    logic vio_s;
    logic rgood_s;
    logic wire_in_s;
    assign sel_n_s = sel_s_q[1];
    assign vio_s = vio_s_q[1];
    assign rgood_s = rgood_s_q[1];
    assign wire_in_s = wire_s_q[1];

    rpm_core_t q;
    rpm_core_t d;

    logic       req;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [3:0] mode;
    logic       wire_mode;
    logic       async_mode;
    logic       pdown;
    logic       bit_tick;
    logic [1:0] irq_stat;

    assign req = (q.tgl_seen[2] != q.tgl_seen[1]);
    assign wr = bus.word[15];
    assign addr = bus.word[14:8];
    assign wdata = bus.word[7:0];
    assign mode = q.pmc[3:0];
    assign wire_mode = q.ifmode[`RPM_IF_WIRE_BIT];
    assign async_mode = q.ifmode[`RPM_IF_ASYNC_BIT];
    assign pdown = (q.state == RPM_PDOWN);
    assign bit_tick = (q.bit_cnt == DIV_LAST);
    assign irq_stat = {fifo_has_space, fifo_not_empty};

    function automatic logic mode_wants_osc(input logic [3:0] m);
        mode_wants_osc = (m != `RPM_PM_POWERDOWN) && (m != `RPM_PM_DEEPSLEEP);
    endfunction

    always_comb begin
        d = q;
        d.tgl_seen = {q.tgl_seen[1:0], tgl_s_q[1]};
        d.fifo_wr = 1'b0;
        d.fifo_rd = 1'b0;
        d.fifo_flush = 1'b0;
        d.cnt = q.cnt + 32'd1;
        d.brownout = ~vio_s; // R10 R22

        // register access from the host
        if (req) begin
            if (wr) begin
                unique case (addr)
                    `RPM_ADDR_PMC: begin
                        d.pmc = wdata; // R8 R9
                        d.osc_en = mode_wants_osc(wdata[3:0]); // R16
                    end
                    `RPM_ADDR_XTAL: d.xtal = wdata[5:0]; // R17
                    `RPM_ADDR_IFMODE: d.ifmode = wdata[3:0];
                    `RPM_ADDR_IRQMASK: d.irq_mask = wdata[1:0];
                    `RPM_ADDR_FIFO: begin
                        d.fifo_wr = ~pdown & ~wire_mode; // R1 R11 R21
                        d.fifo_wdata = wdata;
                    end
                    default: ;
                endcase
            end else begin
                unique case (addr)
                    `RPM_ADDR_PMC: d.rd_data = q.pmc;
                    `RPM_ADDR_PSTAT:
                        d.rd_data = {5'h00, q.osc_en, q.brownout, q.reg_ready}; // R10
                    `RPM_ADDR_XTAL: d.rd_data = {2'h0, q.xtal};
                    `RPM_ADDR_IFMODE: d.rd_data = {4'h0, q.ifmode};
                    `RPM_ADDR_IRQMASK: d.rd_data = {6'h00, q.irq_mask};
                    `RPM_ADDR_IRQSTAT: d.rd_data = {6'h00, irq_stat};
                    `RPM_ADDR_FIFO: begin
                        if (pdown || wire_mode) begin
                            d.rd_data = `RPM_FIFO_UNDEF; // R11 R21
                        end else begin
                            d.rd_data = fifo_rdata; // R1
                            d.fifo_rd = 1'b1;
                        end
                    end
                    default: d.rd_data = 8'h00;
                endcase
            end
        end

        // soft reset: a set reset bit loads every register default and clears itself the next cycle unless a PMC write lands in that cycle
        if (q.pmc[`RPM_PMC_RST_BIT]) begin
            d.xtal = `RPM_XTAL_RESET; // R19
            d.ifmode = `RPM_IFMODE_RESET;
            d.irq_mask = `RPM_IRQMASK_RESET;
            d.osc_en = 1'b1;
            if (!(req && wr && addr == `RPM_ADDR_PMC)) begin
                d.pmc = `RPM_PMC_RESET;
            end
        end

        // power sequencing
        unique case (q.state)
            RPM_SLEEP: begin
                d.cnt = 32'd0;
                d.pmc = `RPM_PMC_RESET; // R13
                d.xtal = `RPM_XTAL_RESET;
                d.ifmode = `RPM_IFMODE_RESET;
                d.irq_mask = `RPM_IRQMASK_RESET;
                d.rd_data = 8'h00;
                d.osc_en = 1'b0;
                d.ready = 1'b0;
                if (sel_n_s) begin
                    d.sel_armed = 1'b1;
                end else if (q.sel_armed) begin
                    d.state = RPM_WAKE; // R14
                    d.sel_armed = 1'b0;
                end
            end
            RPM_WAKE: begin
                d.osc_en = 1'b1; // R16
                if (q.cnt >= 32'(WAKE_CYC - 1)) begin
                    d.state = RPM_PDOWN;
                    d.ready = 1'b1; // R15
                    d.fifo_flush = 1'b1;
                end
            end
            RPM_PDOWN: begin
                if (mode == `RPM_PM_DEEPSLEEP) begin
                    d.state = RPM_SLEEP;
                end else if (mode != `RPM_PM_POWERDOWN) begin
                    d.state = RPM_RAMP; // R9
                end
            end
            RPM_RAMP, RPM_ACTIVE: begin
                if (mode == `RPM_PM_DEEPSLEEP) begin
                    d.state = RPM_SLEEP;
                end else if (mode == `RPM_PM_POWERDOWN) begin
                    d.state = RPM_PDOWN;
                    d.fifo_flush = 1'b1; // R11
                end else if (rgood_s && vio_s) begin
                    d.state = RPM_ACTIVE; // R9
                end else begin
                    d.state = RPM_RAMP;
                end
            end
        endcase

        d.reg_core_en = (d.state == RPM_RAMP) || (d.state == RPM_ACTIVE); // R9 R13
        d.reg_ana_en = d.reg_core_en;
        d.reg_ready = (d.state == RPM_ACTIVE) && rgood_s && vio_s; // R22
        d.rx_en = d.reg_ready && (mode == `RPM_PM_FULLRX); // R9
        d.tx_en = d.reg_ready && (mode == `RPM_PM_FULLTX);
        if (d.state == RPM_SLEEP) begin
            d.osc_en = 1'b0; // R13
        end

        // frame-mode flow interrupt
        d.irq = ~wire_mode && q.reg_ready && |(irq_stat & q.irq_mask); // R3

        // wire-mode bit clock divider
        if (wire_mode && q.reg_ready) begin
            d.bit_cnt = bit_tick ? 16'h0000 : q.bit_cnt + 16'h0001;
            d.bit_clk = (q.bit_cnt < DIV_HALF); // R5
        end else begin
            d.bit_cnt = 16'h0000;
            d.bit_clk = 1'b0;
        end

        // receive: raw modem bits through the latency line onto the data pin
        d.wire_oe = d.ifmode[`RPM_IF_WIRE_BIT] && d.rx_en; // R4
        if (wire_mode && q.rx_en && bit_tick) begin
            d.delay_line = {q.delay_line[4:0], modem_rx_bit}; // R20
            d.wire_out = q.delay_line[`RPM_WIRE_LATENCY_BITS - 1]; // R4 R20
        end

        // transmit: sample host data each bit; async realigns on a start edge
        d.wire_in_prev = wire_in_s;
        if (wire_mode && q.tx_en) begin
            if (bit_tick) begin
                d.tx_bit = wire_in_s;
                d.start_armed = wire_in_s;
            end
            if (async_mode && q.start_armed && q.wire_in_prev && !wire_in_s) begin
                d.bit_cnt = DIV_HALF; // R7
                d.start_armed = 1'b0;
            end
        end else begin
            d.start_armed = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= RPM_WAKE; // R14
            q.pmc <= `RPM_PMC_RESET;
            q.osc_en <= 1'b1; // R16
            q.xtal <= `RPM_XTAL_RESET;
            q.ifmode <= `RPM_IFMODE_RESET;
            q.irq_mask <= `RPM_IRQMASK_RESET;
            q.start_armed <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign bus.rd_data = q.rd_data;
    assign spi_miso = miso_bit & q.ready; // R15
    assign spi_miso_oe = ~spi_sel_n;
    assign wire_data_out = q.wire_out;
    assign wire_data_oe = q.wire_oe;
    assign wire_bit_clock_pin = q.bit_clk;
    assign modem_tx_bit = q.tx_bit;
    assign reg_core_en = q.reg_core_en;
    assign reg_ana_en = q.reg_ana_en;
    assign osc_en = q.osc_en;
    assign rx_en = q.rx_en;
    assign tx_en = q.tx_en;
    assign pkt_ctrl_en = ~q.ifmode[`RPM_IF_WIRE_BIT] & q.reg_ready; // R4
    assign frame_preamble_en = ~q.ifmode[`RPM_IF_WIRE_BIT] & q.ifmode[`RPM_IF_PREAMBLE_BIT]; // R2
    assign frame_crc_en = ~q.ifmode[`RPM_IF_WIRE_BIT] & q.ifmode[`RPM_IF_CRC_BIT]; // R2
    assign spi_slow = (q.state == RPM_PDOWN); // R12
    assign crystal_tuning_cap = q.xtal; // R17
    assign fifo_wr = q.fifo_wr;
    assign fifo_rd = q.fifo_rd;
    assign fifo_flush = q.fifo_flush;
    assign fifo_wdata = q.fifo_wdata;
    assign irq = q.irq;
endmodule

// File: sim/rpm_ctrl_properties.sv
// port assertions of the radio power controller
`timescale 1ns/1ps
`include "rpm_map.svh"
module rpm_ctrl_props
    import rpm_pkg::*;
#(
    parameter int BIT_DIV = `RPM_BIT_DIV_DEFAULT
)(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spi_sel_n,
    input wire logic spi_miso_oe,
    input wire logic fifo_wr,
    input wire logic fifo_rd,
    input wire logic fifo_flush,
    input wire logic wire_data_oe,
    input wire logic wire_bit_clock_pin,
    input wire logic pkt_ctrl_en,
    input wire logic reg_core_en,
    input wire logic reg_ana_en,
    input wire logic rx_en,
    input wire logic tx_en,
    input wire logic osc_en,
    input wire logic spi_slow,
    input wire logic irq
);
    logic [15:0] hi_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hi_q <= 16'h0000;
        end else begin
            hi_q <= wire_bit_clock_pin ? hi_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    miso_enable_a: assert property (spi_miso_oe == !spi_sel_n)
        else $error("miso enable wrong");
    pdown_fifo_a: assert property (spi_slow |-> !fifo_wr && !fifo_rd)
        else $error("fifo access while powered down");
    pdown_supply_a: assert property (spi_slow && $past(spi_slow) |-> !reg_core_en && !rx_en && !tx_en)
        else $error("supplies on while powered down");
    wire_no_pkt_a: assert property (wire_data_oe |-> !pkt_ctrl_en)
        else $error("packet controller on in wire mode");
    radio_supply_a: assert property (rx_en || tx_en |-> reg_core_en && reg_ana_en)
        else $error("radio on without regulators");
    rx_tx_excl_a: assert property (!(rx_en && tx_en))
        else $error("rx and tx both on");
    irq_frame_a: assert property (!pkt_ctrl_en ##1 !pkt_ctrl_en |-> !irq)
        else $error("interrupt outside frame mode");
    flush_pulse_a: assert property (fifo_flush |=> !fifo_flush)
        else $error("flush too long");
    fifo_pulse_a: assert property ((fifo_wr || fifo_rd) |=> (!fifo_wr && !fifo_rd) [*8])
        else $error("fifo strobe not a single pulse");
    bit_clk_half_a: assert property (disable iff (!rst_n || !wire_data_oe)
        $fell(wire_bit_clock_pin) |-> hi_q == 16'(BIT_DIV / 2))
        else $error("bit clock high phase");
    osc_wake_a: assert property ($rose(rst_n) |-> osc_en)
        else $error("oscillator off after power-up");
    cover property (fifo_wr);
    cover property (rx_en ##1 tx_en);
    cover property ($fell(wire_bit_clock_pin) && wire_data_oe);
    cover property (irq);
endmodule

bind rpm_ctrl rpm_ctrl_props #(.BIT_DIV(BIT_DIV)) u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi_sel_n(spi_sel_n),
    .spi_miso_oe(spi_miso_oe), .fifo_wr(fifo_wr), .fifo_rd(fifo_rd), .fifo_flush(fifo_flush),
    .wire_data_oe(wire_data_oe), .wire_bit_clock_pin(wire_bit_clock_pin),
    .pkt_ctrl_en(pkt_ctrl_en), .reg_core_en(reg_core_en), .reg_ana_en(reg_ana_en),
    .rx_en(rx_en), .tx_en(tx_en), .osc_en(osc_en), .spi_slow(spi_slow), .irq(irq)
);

// File: sim/rpm_host_model.sv
// host controller model acting as spi master
`timescale 1ns/1ps
module rpm_host_model (
    output logic     spi_sck,
    output logic     spi_sel_n,
    output logic     spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_slow
);
    initial begin
        spi_sck = 1'b0;
        spi_sel_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // one 16 bit word per frame; read byte of the previous word on edges 2..9
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
        realtime h;
        h = spi_slow ? 50.0 : 7.5;
        spi_sel_n = 1'b0;
        #10.0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = w[i];
            #(h);
            spi_sck = 1'b1;
            if (i <= 14 && i >= 7) begin
                rd[i-7] = spi_miso;
            end
            #(h);
            spi_sck = 1'b0;
        end
        spi_mosi = ~spi_mosi;
        #10.0;
        spi_sel_n = 1'b1;
        #100.0;
    endtask
    // select low wakes the device, then miso is polled until high
    task automatic wake(output int n, output logic first);
        spi_sel_n = 1'b0;
        #1.0;
        first = spi_miso;
        n = 0;
        while (spi_miso !== 1'b1 && n < 500) begin
            #4.0;
            n++;
        end
        spi_sel_n = 1'b1;
        #100.0;
    endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench of the radio power controller
`timescale 1ns/1ps
`include "rpm_map.svh"
module tb_top;
    logic       clk_sys, rst_n, vio_ok, regs_good, modem_rx_bit, wire_data_in;
    logic       fifo_not_empty, fifo_has_space, p, f;
    logic [7:0] fifo_rdata, fifo_wdata, wdat;
    logic [5:0] crystal_tuning_cap;
    logic       spi_sck, spi_sel_n, spi_mosi, spi_miso, spi_miso_oe, wire_data_out;
    logic       wire_data_oe, wire_bit_clock_pin, modem_tx_bit, reg_core_en, reg_ana_en;
    logic       osc_en, rx_en, tx_en, pkt_ctrl_en, frame_preamble_en, frame_crc_en;
    logic       spi_slow, fifo_wr, fifo_rd, fifo_flush, irq;
    int         fails, checks, flushes, k, n, r;

    rpm_ctrl #(.BIT_DIV(8)) dut (
        .clk_sys, .rst_n, .spi_sck, .spi_sel_n, .spi_mosi, .spi_miso, .spi_miso_oe, .vio_ok,
        .regs_good, .modem_rx_bit, .wire_data_in, .wire_data_out, .wire_data_oe,
        .wire_bit_clock_pin, .modem_tx_bit, .reg_core_en, .reg_ana_en, .osc_en, .rx_en,
        .tx_en, .pkt_ctrl_en, .frame_preamble_en, .frame_crc_en, .spi_slow,
        .crystal_tuning_cap, .fifo_wr, .fifo_rd, .fifo_flush, .fifo_wdata, .fifo_rdata,
        .fifo_not_empty, .fifo_has_space, .irq
    );
    rpm_host_model host (.spi_sck, .spi_sel_n, .spi_mosi, .spi_miso, .spi_slow);

    always @(posedge clk_sys) begin
        if (fifo_wr === 1'b1) wdat <= fifo_wdata;
        if (fifo_flush === 1'b1) flushes <= flushes + 1;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] x;
        host.xfer({1'b1, a, v}, x);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] x;
        host.xfer({1'b0, a, 8'h00}, x);
        host.xfer({1'b0, 7'h7F, 8'h00}, x);
        check(x & m, e);
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #300us;
        fails++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        vio_ok = 1'b1;
        regs_good = 1'b0;
        modem_rx_bit = 1'b0;
        wire_data_in = 1'b1;
        fifo_not_empty = 1'b0;
        fifo_has_space = 1'b0;
        fifo_rdata = 8'h00;
        cyc(6);
        check(8'({osc_en, crystal_tuning_cap}), 8'h48);
        check(8'(spi_miso), 8'h00);
        rst_n <= 1'b1;
        cyc(300);
        check(8'({spi_miso, spi_slow}), 8'h03);
        check(8'(flushes), 8'h01);
        $display("test reset done");
        wr(`RPM_ADDR_XTAL, 8'h15);
        check(8'(crystal_tuning_cap), 8'h15);
        rdc(`RPM_ADDR_XTAL, 8'hFF, 8'h15);
        rdc(`RPM_ADDR_IFMODE, 8'hFF, 8'h0C);
        rdc(7'h7F, 8'hFF, 8'h00);
        wr(`RPM_ADDR_FIFO, 8'h33);
        rdc(`RPM_ADDR_FIFO, 8'hFF, `RPM_FIFO_UNDEF);
        $display("test registers done");
        wr(`RPM_ADDR_PMC, {4'h0, `RPM_PM_STANDBY});
        check(8'({reg_core_en, spi_slow}), 8'h02);
        rdc(`RPM_ADDR_PSTAT, 8'h03, 8'h00);
        @(posedge clk_sys);
        regs_good <= 1'b1;
        cyc(10);
        rdc(`RPM_ADDR_PSTAT, 8'h03, 8'h01);
        wr(`RPM_ADDR_PMC, {4'h0, `RPM_PM_FULLTX});
        check(8'({rx_en, tx_en}), 8'h01);
        @(posedge clk_sys);
        vio_ok <= 1'b0;
        cyc(10);
        rdc(`RPM_ADDR_PSTAT, 8'h03, 8'h02);
        @(posedge clk_sys);
        vio_ok <= 1'b1;
        cyc(10);
        rdc(`RPM_ADDR_PSTAT, 8'h03, 8'h01);
        wr(`RPM_ADDR_PMC, {4'h0, `RPM_PM_FULLRX});
        check(8'({rx_en, tx_en}), 8'h02);
        $display("test power done");
        check(8'({pkt_ctrl_en, frame_preamble_en, frame_crc_en}), 8'h07);
        for (int i = 0; i < 2; i++) begin
            wr(`RPM_ADDR_IRQMASK, 8'(1 << i));
            @(posedge clk_sys);
            {fifo_has_space, fifo_not_empty} <= 2'(1 << i);
            cyc(10);
            check(8'(irq), 8'h01);
            @(posedge clk_sys);
            {fifo_has_space, fifo_not_empty} <= 2'b00;
            fifo_rdata <= 8'h5A;
            cyc(10);
            check(8'(irq), 8'h00);
        end
        rdc(`RPM_ADDR_FIFO, 8'hFF, 8'h5A);
        wr(`RPM_ADDR_FIFO, 8'hA5);
        check(wdat, 8'hA5);
        $display("test frame done");
        wr(`RPM_ADDR_IFMODE, 8'h01);
        check(8'({pkt_ctrl_en, wire_data_oe}), 8'h01);
        @(posedge clk_sys);
        modem_rx_bit <= 1'b1;
        #1;
        p = wire_bit_clock_pin;
        r = 0;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_sys);
            #1;
            if (wire_bit_clock_pin === 1'b1 && p === 1'b0) r++;
            p = wire_bit_clock_pin;
            if (i == 23) check(8'(wire_data_out), 8'h00);
        end
        check(8'(wire_data_out), 8'h01);
        check(8'(r), 8'd10);
        wr(`RPM_ADDR_PMC, {4'h0, `RPM_PM_FULLTX});
        check(8'(modem_tx_bit), 8'h01);
        wr(`RPM_ADDR_IFMODE, 8'h03);
        @(posedge clk_sys);
        wire_data_in <= 1'b0;
        cyc(10);
        check(8'(modem_tx_bit), 8'h00);
        $display("test wire done");
        wr(`RPM_ADDR_IFMODE, `RPM_IFMODE_RESET);
        k = flushes;
        wr(`RPM_ADDR_PMC, `RPM_PMC_RESET);
        check(8'({spi_slow, reg_core_en, rx_en}), 8'h04);
        check(8'(flushes - k), 8'h01);
        rdc(`RPM_ADDR_XTAL, 8'hFF, 8'h15);
        wr(`RPM_ADDR_PMC, 8'h80);
        wr(`RPM_ADDR_PMC, 8'h00);
        rdc(`RPM_ADDR_XTAL, 8'hFF, `RPM_XTAL_RESET);
        $display("test soft reset done");
        wr(`RPM_ADDR_XTAL, 8'h15);
        wr(`RPM_ADDR_PMC, {4'h0, `RPM_PM_DEEPSLEEP});
        check(8'({osc_en, reg_core_en}), 8'h00);
        host.wake(n, f);
        check(8'(f), 8'h00);
        check(8'(n >= 250 && n <= 280), 8'h01);
        rdc(`RPM_ADDR_XTAL, 8'hFF, `RPM_XTAL_RESET);
        $display("test deep sleep done");
        end_sim();
    end
endmodule
